// >>> hk_defines.svh
// Purpose: Offsets, reset values, field positions and timing counts of the register bank
// Assumes: Byte addressing, 16-bit registers at even/odd address pairs
// Notes: Definitions only
`ifndef HK_DEFINES_SVH
`define HK_DEFINES_SVH
`define HK_ADDR_PAGE_LO 7'h00
`define HK_ADDR_PAGE_HI 7'h01
`define HK_ADDR_TEMP_LO 7'h02
`define HK_ADDR_TEMP_HI 7'h03
`define HK_ADDR_SUPPLY_LO 7'h04
`define HK_ADDR_SUPPLY_HI 7'h05
`define HK_ADDR_AVG_LO 7'h06
`define HK_ADDR_AVG_HI 7'h07
`define HK_PAGE_RESET 16'h0000
`define HK_MEAS_RESET 16'h8000
`define HK_AVG_RESET 16'h0108
`define HK_PAGE_MAX 16'h0006
`define HK_SUPPLY_MSB 11
`define HK_SAMPLES 13'h1000
`define HK_COUNT_ONE 8'h01
`define HK_SPI_WRITE_BIT 15
`endif

// >>> hk_pkg.sv
// Purpose: Types shared by the housekeeping register bank
// Assumes: hk_defines.svh holds the numeric constants
// Notes: Types only
package hk_pkg;
  typedef struct packed {
    logic valid;
    logic write;
    logic [6:0] addr;
    logic [7:0] data;
  } spi_cmd_t;
  typedef struct packed {
    logic [11:0] supply;
    logic [15:0] temp;
  } meas_t;
  typedef enum logic [1:0] {
    AVG_IDLE = 2'b00,
    AVG_CAPTURE = 2'b01,
    AVG_MEASURE = 2'b10,
    AVG_FINISH = 2'b11
  } avg_state_t;
endpackage : hk_pkg

// >>> hk_accum.sv
// Purpose: Running accumulator for one measurement channel
// Assumes: At most 255 addends
// Notes: Width grows by eight bits over the sample
`timescale 1ns/1ps
`default_nettype none
module hk_accum #(
  parameter int W = 16
) (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic clear_i,
  input wire logic add_i,
  input wire logic [W-1:0] value_i,
  output logic [W+7:0] sum_o
);
  logic [W+7:0] sum_reg;
  logic [W+7:0] sum_next;
  always_comb begin
    sum_next = sum_reg;
    if (clear_i) begin
      sum_next = '0;
    end else if (add_i) begin
      sum_next = sum_reg + {8'h00, value_i};
    end
  end
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      sum_reg <= '0;
    end else begin
      sum_reg <= sum_next;
    end
  end
  assign sum_o = sum_reg;
endmodule : hk_accum
`default_nettype wire

// >>> hk_regs.sv
// Purpose: Paged register bank with temperature, supply and low-rate averaging control
// Assumes: SPI framing decoded upstream into byte commands on CLK_I
// Notes: Measurement and sample strobes come from logic on the same clock
//
// How it works
// - Seven pages 0..6 exist; page 0 holds these registers, pages 1..6 coefficient banks.
// - The page select register sits at bytes 0x00/0x01 of every page and resets to 0x0000.
// - After a page number is written, later writes go to that page.
// - Temperature at 0x02/0x03 of page 0 updates at the end of each capture.
// - Temperature code is (T - 460 C)/(-0.46 C), produced by the sensor front end.
// - Temperature reads 0x8000 until the first capture completes, supply until the first record of the first capture is measured.
// - Supply at 0x04/0x05 of page 0 updates after the first acquisition of each capture, and with the average at its end if count > 1.
// - Supply carries 12 bits of 3.22 mV counts; once measured, the upper four bits read zero.
// - The low-rate averaging register is read/write and resets to 0x0108.
// - Bits 15:8 count records for rate one, bits 7:0 for rate zero, range 1..255.
// - Averaging captures 4096 samples, transforms and accumulates until the count is met.
// - Supply and temperature are measured after each acquisition and accumulated.
// - Writing the page select only redirects access; stored values stay.
`timescale 1ns/1ps
`default_nettype none
`include "hk_defines.svh"
module hk_regs (
  input wire logic CLK_I, // 250 MHz clock
  input wire logic RESET_I, // Synchronous reset, active high
  input wire hk_pkg::spi_cmd_t CMD_I, // Decoded byte command
  output logic [7:0] RDATA_O, // Read byte, registered
  output logic [15:0] PAGE_O, // Current page
  output logic COEF_WE_O, // Coefficient byte write to pages 1..6
  output logic [7:0] COEF_ADDR_O, // Coefficient byte address
  output logic [7:0] COEF_DATA_O, // Coefficient byte data
  input wire logic START_I, // Capture request pulse
  input wire logic RATE_ONE_I, // Rate setting one selected, else zero
  input wire logic SPECTRAL_I, // Spectral modes, else time capture
  input wire logic SAMPLE_I, // One sample acquired
  input wire logic MEAS_VALID_I, // Measurement ready pulse
  input wire hk_pkg::meas_t MEAS_I, // Measured supply and temperature
  output logic XFORM_O, // Transform and accumulate pulse
  output logic BUSY_O, // Capture in progress
  output logic DONE_O, // Capture complete pulse
  output logic [7:0] RECORDS_O // Records accumulated so far
);
  import hk_pkg::*;

  logic [15:0] page_reg, page_next;
  logic [15:0] temp_reg, temp_next;
  logic [15:0] supply_reg, supply_next;
  logic [15:0] avg_reg, avg_next;
  logic [7:0] rdata_reg, rdata_next;
  logic cwe_reg, cwe_next;
  logic [7:0] caddr_reg, caddr_next, cdata_reg, cdata_next;
  avg_state_t state_reg, state_next;
  logic [12:0] samp_reg, samp_next;
  logic [7:0] rec_reg, rec_next, target_reg, target_next;
  logic done_reg, done_next, xform_reg, xform_next;
  logic acc_clear, acc_add;
  logic [23:0] temp_sum;
  logic [19:0] supply_sum;
  logic wr, on_page0;

  assign wr = CMD_I.valid && CMD_I.write;
  assign on_page0 = (page_reg == `HK_PAGE_RESET);

  // Register writes and reads
  always_comb begin
    page_next = page_reg;
    avg_next = avg_reg;
    cwe_next = 1'b0;
    caddr_next = caddr_reg;
    cdata_next = cdata_reg;
    rdata_next = rdata_reg;
    if (wr) begin
      if (CMD_I.addr == `HK_ADDR_PAGE_LO) begin
        page_next = {page_reg[15:8], CMD_I.data};
      end else if (CMD_I.addr == `HK_ADDR_PAGE_HI) begin
        page_next = {CMD_I.data, page_reg[7:0]};
      end else if (on_page0) begin
        if (CMD_I.addr == `HK_ADDR_AVG_LO) begin
          avg_next = {avg_reg[15:8], CMD_I.data};
        end else if (CMD_I.addr == `HK_ADDR_AVG_HI) begin
          avg_next = {CMD_I.data, avg_reg[7:0]};
        end
        // Temperature and supply addresses fall through untouched
      end else if (page_reg <= `HK_PAGE_MAX) begin
        cwe_next = 1'b1;
        caddr_next = {1'b0, CMD_I.addr};
        cdata_next = CMD_I.data;
      end
    end
    if (CMD_I.valid && !CMD_I.write) begin
      case (CMD_I.addr)
        `HK_ADDR_PAGE_LO: rdata_next = page_reg[7:0];
        `HK_ADDR_PAGE_HI: rdata_next = page_reg[15:8];
        `HK_ADDR_TEMP_LO: rdata_next = on_page0 ? temp_reg[7:0] : 8'h00;
        `HK_ADDR_TEMP_HI: rdata_next = on_page0 ? temp_reg[15:8] : 8'h00;
        `HK_ADDR_SUPPLY_LO: rdata_next = on_page0 ? supply_reg[7:0] : 8'h00;
        `HK_ADDR_SUPPLY_HI: rdata_next = on_page0 ? supply_reg[15:8] : 8'h00;
        `HK_ADDR_AVG_LO: rdata_next = on_page0 ? avg_reg[7:0] : 8'h00;
        `HK_ADDR_AVG_HI: rdata_next = on_page0 ? avg_reg[15:8] : 8'h00;
        default: rdata_next = 8'h00;
      endcase
    end
  end

  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      page_reg <= `HK_PAGE_RESET;
      avg_reg <= `HK_AVG_RESET;
      rdata_reg <= 8'h00;
      cwe_reg <= 1'b0;
      caddr_reg <= 8'h00;
      cdata_reg <= 8'h00;
    end else begin
      page_reg <= page_next;
      avg_reg <= avg_next;
      rdata_reg <= rdata_next;
      cwe_reg <= cwe_next;
      caddr_reg <= caddr_next;
      cdata_reg <= cdata_next;
    end
  end

  hk_accum #(.W(16)) u_temp_acc (
    .clk_i(CLK_I),
    .reset_i(RESET_I),
    .clear_i(acc_clear),
    .add_i(acc_add),
    .value_i(MEAS_I.temp),
    .sum_o(temp_sum)
  );
  hk_accum #(.W(12)) u_supply_acc (
    .clk_i(CLK_I),
    .reset_i(RESET_I),
    .clear_i(acc_clear),
    .add_i(acc_add),
    .value_i(MEAS_I.supply),
    .sum_o(supply_sum)
  );

  // Capture and averaging sequence
  always_comb begin
    state_next = state_reg;
    samp_next = samp_reg;
    rec_next = rec_reg;
    target_next = target_reg;
    temp_next = temp_reg;
    supply_next = supply_reg;
    done_next = 1'b0;
    xform_next = 1'b0;
    acc_clear = 1'b0;
    acc_add = 1'b0;
    case (state_reg)
      AVG_IDLE: begin
        if (START_I) begin
          acc_clear = 1'b1;
          samp_next = 13'h0000;
          rec_next = 8'h00;
          // Zero count treated as one record
          target_next = RATE_ONE_I ? avg_reg[15:8] : avg_reg[7:0];
          if (!SPECTRAL_I || target_next == 8'h00) begin
            target_next = `HK_COUNT_ONE;
          end
          state_next = AVG_CAPTURE;
        end
      end
      AVG_CAPTURE: begin
        if (SAMPLE_I) begin
          samp_next = samp_reg + 13'h0001;
          if (samp_next == `HK_SAMPLES) begin
            state_next = AVG_MEASURE;
            xform_next = SPECTRAL_I;
          end
        end
      end
      AVG_MEASURE: begin
        if (MEAS_VALID_I) begin
          acc_add = 1'b1;
          if (rec_reg == 8'h00) begin
            supply_next = {4'h0, MEAS_I.supply[`HK_SUPPLY_MSB:0]};
          end
          rec_next = rec_reg + 8'h01;
          samp_next = 13'h0000;
          state_next = (rec_next == target_reg) ? AVG_FINISH : AVG_CAPTURE;
        end
      end
      AVG_FINISH: begin
        temp_next = 16'((temp_sum / {16'h0000, target_reg}));
        if (target_reg != `HK_COUNT_ONE) begin
          supply_next = {4'h0, 12'((supply_sum / {12'h000, target_reg}))};
        end
        done_next = 1'b1;
        state_next = AVG_IDLE;
      end
      default: state_next = AVG_IDLE;
    endcase
  end

  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      state_reg <= AVG_IDLE;
      samp_reg <= 13'h0000;
      rec_reg <= 8'h00;
      target_reg <= `HK_COUNT_ONE;
      temp_reg <= `HK_MEAS_RESET;
      supply_reg <= `HK_MEAS_RESET;
      done_reg <= 1'b0;
      xform_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      samp_reg <= samp_next;
      rec_reg <= rec_next;
      target_reg <= target_next;
      temp_reg <= temp_next;
      supply_reg <= supply_next;
      done_reg <= done_next;
      xform_reg <= xform_next;
    end
  end

  assign RDATA_O = rdata_reg;
  assign PAGE_O = page_reg;
  assign COEF_WE_O = cwe_reg;
  assign COEF_ADDR_O = caddr_reg;
  assign COEF_DATA_O = cdata_reg;
  assign XFORM_O = xform_reg;
  assign BUSY_O = (state_reg != AVG_IDLE);
  assign DONE_O = done_reg;
  assign RECORDS_O = rec_reg;

  property p_page_write;
    @(posedge CLK_I) disable iff (RESET_I)
    (wr && CMD_I.addr == `HK_ADDR_PAGE_LO) |=> (page_reg[7:0] == $past(CMD_I.data));
  endproperty
  a_page_write: assert property (p_page_write) else $error("page low byte not stored");

  property p_avg_keep_on_page;
    @(posedge CLK_I) disable iff (RESET_I)
    (wr && !on_page0) |=> (avg_reg == $past(avg_reg));
  endproperty
  a_avg_keep_on_page: assert property (p_avg_keep_on_page) else $error("avg changed off page 0");

  property p_coef_route;
    @(posedge CLK_I) disable iff (RESET_I)
    (wr && !on_page0 && page_reg <= `HK_PAGE_MAX && CMD_I.addr > `HK_ADDR_PAGE_HI)
      |=> COEF_WE_O;
  endproperty
  a_coef_route: assert property (p_coef_route) else $error("coefficient write lost");

  property p_temp_only_at_done;
    @(posedge CLK_I) disable iff (RESET_I)
    (temp_reg != $past(temp_reg)) |-> DONE_O;
  endproperty
  a_temp_only_at_done: assert property (p_temp_only_at_done) else $error("temp moved");

  property p_ro_ignored;
    @(posedge CLK_I) disable iff (RESET_I)
    (wr && on_page0 && !BUSY_O && (CMD_I.addr >= `HK_ADDR_TEMP_LO &&
      CMD_I.addr <= `HK_ADDR_SUPPLY_HI)) |=> $stable(temp_reg) && $stable(supply_reg);
  endproperty
  a_ro_ignored: assert property (p_ro_ignored) else $error("read-only register written");

  property p_supply_top_zero;
    @(posedge CLK_I) disable iff (RESET_I)
    (supply_reg != `HK_MEAS_RESET) |-> (supply_reg[15:12] == 4'h0);
  endproperty
  a_supply_top_zero: assert property (p_supply_top_zero) else $error("supply top bits set");

  property p_rec_bound;
    @(posedge CLK_I) disable iff (RESET_I)
    BUSY_O |-> (rec_reg <= target_reg);
  endproperty
  a_rec_bound: assert property (p_rec_bound) else $error("record count overrun");

  property p_meas_accum;
    @(posedge CLK_I) disable iff (RESET_I)
    (state_reg == AVG_MEASURE && MEAS_VALID_I) |=> (rec_reg == $past(rec_reg) + 8'h01);
  endproperty
  a_meas_accum: assert property (p_meas_accum) else $error("record not counted");

  property p_page_no_side;
    @(posedge CLK_I) disable iff (RESET_I)
    (wr && CMD_I.addr == `HK_ADDR_PAGE_HI) |=> $stable(avg_reg);
  endproperty
  a_page_no_side: assert property (p_page_no_side) else $error("page write altered data");

  property p_supply_at_start;
    @(posedge CLK_I) disable iff (RESET_I)
    (state_reg == AVG_MEASURE && MEAS_VALID_I && rec_reg == 8'h00) |=>
      (supply_reg == {4'h0, $past(MEAS_I.supply)});
  endproperty
  a_supply_at_start: assert property (p_supply_at_start) else $error("supply missed");

  property p_busy_on_start;
    @(posedge CLK_I) disable iff (RESET_I)
    (!BUSY_O && START_I) |=> BUSY_O;
  endproperty
  a_busy_on_start: assert property (p_busy_on_start) else $error("capture not started");

  c_done: cover property (@(posedge CLK_I) disable iff (RESET_I) DONE_O);
  c_multi: cover property (@(posedge CLK_I) disable iff (RESET_I) DONE_O && target_reg > 8'h01);
  c_coef: cover property (@(posedge CLK_I) disable iff (RESET_I) COEF_WE_O);
  c_time: cover property (@(posedge CLK_I) disable iff (RESET_I) DONE_O && !SPECTRAL_I);
endmodule : hk_regs
`default_nettype wire

// >>> hk_host_model.sv
// Purpose: Host model issuing byte commands to the register bank
// Assumes: One command per two cycles, launched on the falling edge
// Notes: Idle fields carry the inverse of the last command
`timescale 1ns/1ps
`default_nettype none
module hk_host_model (
  input wire logic clk_i, // Bank clock
  input wire logic [7:0] rdata_i, // Read byte
  output var hk_pkg::spi_cmd_t cmd_o // Command to bank
);
  import hk_pkg::*;
  initial cmd_o = '0;
  task automatic send(input logic wr, input logic [6:0] a, input logic [7:0] d,
      output logic [7:0] q);
    @(negedge clk_i);
    cmd_o = '{valid: 1'b1, write: wr, addr: a, data: d};
    @(negedge clk_i);
    q = rdata_i;
    cmd_o = '{valid: 1'b0, write: ~wr, addr: ~a, data: ~d};
  endtask : send
  // Low byte first, then high byte
  task automatic put16(input logic [6:0] a, input logic [15:0] v);
    logic [7:0] q;
    send(1'b1, a, v[7:0], q);
    send(1'b1, a + 7'h01, v[15:8], q);
  endtask : put16
  task automatic get16(input logic [6:0] a, output logic [15:0] v);
    send(1'b0, a, 8'h00, v[7:0]);
    send(1'b0, a + 7'h01, 8'h00, v[15:8]);
  endtask : get16
endmodule : hk_host_model
`default_nettype wire

// >>> test_paged_housekeeping_avg_regs.sv
// Purpose: Self-checking bench for the paged register bank
// Assumes: Host model drives commands, bench drives the capture front end
// Notes: Measurements step by two so averages are exact
`timescale 1ns/1ps
`default_nettype none
module test_paged_housekeeping_avg_regs;
  import hk_pkg::*;
  logic clk_i, reset_i, start_i, rate_one_i, spectral_i, sample_i, meas_valid_i;
  logic coef_we, xform, busy, done;
  logic [7:0] rdata, coef_addr, coef_data, records, q;
  logic [15:0] page, v, e, tprev;
  meas_t meas_i;
  spi_cmd_t cmd;
  int fails, checked, cycles;
  hk_regs uut (.CLK_I(clk_i), .RESET_I(reset_i), .CMD_I(cmd), .RDATA_O(rdata),
    .PAGE_O(page), .COEF_WE_O(coef_we), .COEF_ADDR_O(coef_addr),
    .COEF_DATA_O(coef_data), .START_I(start_i), .RATE_ONE_I(rate_one_i),
    .SPECTRAL_I(spectral_i), .SAMPLE_I(sample_i), .MEAS_VALID_I(meas_valid_i),
    .MEAS_I(meas_i), .XFORM_O(xform), .BUSY_O(busy), .DONE_O(done),
    .RECORDS_O(records));
  hk_host_model hm (.clk_i(clk_i), .rdata_i(rdata), .cmd_o(cmd));
  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 90000) begin
      fails = fails + 1;
      close_out();
    end
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checked = checked + 1;
    if (seen !== exp) begin
      fails = fails + 1;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  // Mean of base, base+2, ... over n records
  function automatic logic [15:0] mean_of(input logic [15:0] base, input int n);
    logic [23:0] sum;
    sum = '0;
    for (int r = 0; r < n; r++) sum = sum + 24'(base) + 24'(2 * r);
    return 16'(sum / 24'(n));
  endfunction : mean_of
  task automatic close_out;
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : close_out
  task automatic capture(input int n, input logic r1, input logic sp,
      input logic [15:0] t0, input logic [11:0] s0);
    int k;
    rate_one_i = r1;
    spectral_i = sp;
    start_i = 1'b1;
    @(negedge clk_i);
    start_i = 1'b0;
    check(16'(busy), 16'h0001);
    for (int r = 0; r < n; r++) begin
      repeat (4095) begin
        sample_i = 1'b1;
        @(negedge clk_i);
        sample_i = 1'b0;
        @(negedge clk_i);
      end
      sample_i = 1'b1;
      @(negedge clk_i);
      sample_i = 1'b0;
      k = 0;
      while (xform !== 1'b1 && k < 4) begin
        @(negedge clk_i);
        k = k + 1;
      end
      check(16'(xform), 16'(sp));
      meas_i = '{supply: s0 + 12'(2 * r), temp: t0 + 16'(2 * r)};
      meas_valid_i = 1'b1;
      @(negedge clk_i);
      meas_valid_i = 1'b0;
      check(16'(records), 16'(r + 1));
      if (r == 0 && n > 1) begin
        hm.get16(7'h04, v);
        check(v, {4'h0, s0});
        hm.get16(7'h02, v);
        check(v, tprev);
      end
    end
    k = 0;
    while (done !== 1'b1 && k < 8) begin
      @(negedge clk_i);
      k = k + 1;
    end
    check(16'(done), 16'h0001);
    check(16'(busy), 16'h0000);
    check(16'(records), 16'(n));
    tprev = mean_of(t0, n);
    hm.get16(7'h02, v);
    check(v, tprev);
    hm.get16(7'h04, v);
    check(v, {4'h0, 12'(mean_of({4'h0, s0}, n))});
  endtask : capture
  initial begin
    reset_i = 1'b1;
    start_i = 1'b0;
    rate_one_i = 1'b0;
    spectral_i = 1'b1;
    sample_i = 1'b0;
    meas_valid_i = 1'b0;
    meas_i = '0;
    tprev = 16'h8000;
    void'($urandom(32'h3a4c));
    repeat (2) @(negedge clk_i);
    reset_i = 1'b0;
    check(page, 16'h0000);
    hm.get16(7'h00, v);
    check(v, 16'h0000);
    hm.get16(7'h02, v);
    check(v, 16'h8000);
    hm.get16(7'h04, v);
    check(v, 16'h8000);
    hm.get16(7'h06, v);
    check(v, 16'h0108);
    hm.put16(7'h02, 16'h1234);
    hm.put16(7'h04, 16'h5678);
    hm.get16(7'h02, v);
    check(v, 16'h8000);
    hm.get16(7'h04, v);
    check(v, 16'h8000);
    hm.put16(7'h06, 16'h0101);
    hm.get16(7'h06, v);
    check(v, 16'h0101);
    repeat (4) begin
      e = {8'($urandom_range(255, 1)), 8'($urandom_range(255, 1))};
      hm.put16(7'h06, e);
      hm.get16(7'h06, v);
      check(v, e);
    end
    hm.put16(7'h00, 16'h0002);
    check(page, 16'h0002);
    hm.get16(7'h00, v);
    check(v, 16'h0002);
    hm.send(1'b1, 7'h06, 8'h5a, q);
    check(16'(coef_we), 16'h0001);
    check({coef_addr, coef_data}, 16'h065a);
    hm.put16(7'h00, 16'h0000);
    hm.get16(7'h06, v);
    check(v, e);
    hm.put16(7'h06, 16'h0302);
    capture(2, 1'b0, 1'b1, 16'h0365, 12'h400);
    capture(3, 1'b1, 1'b1, 16'h03bc, 12'h3a2);
    capture(1, 1'b0, 1'b0, 16'h043f, 12'h45d);
    close_out();
  end
endmodule : test_paged_housekeeping_avg_regs
`default_nettype wire
